// ### fcw_pkg.sv
// Constants, field layout and state codes for the fieldbus communication watchdog
package fcw_pkg;
  // Parameter addresses of the settings
  localparam logic [15:0] NODE_CFG_ADDR = 16'h00e6;
  localparam logic [15:0] IP_RST_ADDR = 16'h0207;
  localparam logic [15:0] TIMEOUT_ADDR = 16'h025b;
  localparam logic [15:0] AOUT_MASK_ADDR = 16'h025c;

  // Field positions inside the shared node configuration word
  localparam int NODE_LSB = 0;
  localparam int RATE_LSB = 8;
  localparam int STYLE_LSB = 12;

  // Reset values
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] NODE_RST = 8'h00;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [3:0] STYLE_RST = 4'h0;
  localparam logic [15:0] IP_RST_RST = 16'h0000;

  // Legal ranges
  localparam logic [15:0] TIMEOUT_MAX = 16'hea60;
  localparam logic [7:0] NODE_MAX_PROFILE = 8'h7e;
  localparam logic [7:0] NODE_MAX_OTHER = 8'h3f;
  localparam logic [3:0] RATE_MAX = 4'h3;
  localparam logic [3:0] STYLE_MAX = 4'h2;

  // Link rate codes
  localparam logic [3:0] RATE_125K = 4'h0;
  localparam logic [3:0] RATE_250K = 4'h1;
  localparam logic [3:0] RATE_500K = 4'h2;
  localparam logic [3:0] RATE_AUTO = 4'h3;

  // Keepalive style codes
  localparam logic [3:0] STYLE_LEVEL = 4'h0;
  localparam logic [3:0] STYLE_TOGGLE = 4'h1;
  localparam logic [3:0] STYLE_BOARD = 4'h2;

  // Keepalive bit positions
  localparam int DIN_KEEP_BIT = 15;
  localparam int CTRL_KEEP_BIT = 11;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_IN_NS = 1000000;
  localparam int CYCLES_PER_MS = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 18;
  localparam int KEY_HOLD_S = 5;
  localparam int KEY_HOLD_MS = KEY_HOLD_S * 1000;
  localparam int KEY_CNT_W = 13;

  // Supervision states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_TRIP = 3'b100
  } fcw_state_type;
endpackage

// ### fcw_ms_tick.sv
// Millisecond timebase for the watchdog, restartable
`timescale 1ns/1ps
module fcw_ms_tick #(
  parameter int unsigned CYCLES_PER_MS = fcw_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic ms_tick
);
  import fcw_pkg::*;

  localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(CYCLES_PER_MS - 1);

  logic [TICK_CNT_W-1:0] cnt_reg; // Cycles into the current millisecond
  logic [TICK_CNT_W-1:0] cnt_next;

  // Restart aligns the millisecond grid to the latest legal message
  always_comb
  begin
    if (restart || cnt_reg == LAST)
      cnt_next = '0;
    else
      cnt_next = cnt_reg + TICK_CNT_W'(1);
  end

  // Counter register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  // One pulse per full millisecond
  assign ms_tick = (cnt_reg == LAST) && !restart;

  a_tick_restart: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> !ms_tick)
    else $error("ms tick right after restart");
endmodule

// ### fcw_comm_watchdog.sv
// Fieldbus communication watchdog with its settings store
// Overview of operation
// - Alarm when no legal message within timeout
// - Zero timeout never raises the alarm
// - Digital input word keepalive per style
// - Profile variant: control word bit 11
// - Supervision idle until first legal message
// - No alarm when fieldbus unused for commands
// - Restore link, keepalive, then board reset
// - Zero timeout plus reset clears alarm
// - Saved settings apply after reset only
// - Timeout 0 to 60000 ms, default zero
// - Three-bit analog output override mask
// - Node address bits 0-7, range per protocol
// - Rate bits 8-11, style bits 12-15
// - Rate codes 125k, 250k, 500k, auto
// - Style: level, toggle, board state
`timescale 1ns/1ps
module fcw_comm_watchdog #(
  parameter int unsigned CYCLES_PER_MS = fcw_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] par_addr,
  input wire logic par_wr,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  input wire logic profile_mode,
  input wire logic din_word_wr,
  input wire logic [15:0] din_word,
  input wire logic ctrl_word_wr,
  input wire logic [15:0] ctrl_word,
  input wire logic iface_board_ok,
  input wire logic ctrl_method_fb,
  input wire logic source_sel_fb,
  input wire logic local_remote_input,
  input wire logic board_reset_command,
  input wire logic reset_key,
  output logic comm_suspended_alarm,
  output logic supervision_armed,
  output logic [15:0] link_timeout_setting,
  output logic [2:0] aout_override_mask,
  output logic [7:0] node_id_setting,
  output logic [3:0] link_rate_setting,
  output logic [3:0] keepalive_style_setting
);
  import fcw_pkg::*;

  // Check of a node configuration word against the ranges
  function automatic logic node_cfg_ok(input logic [15:0] w, input logic prof);
    logic [7:0] node_max;
    node_max = prof ? NODE_MAX_PROFILE : NODE_MAX_OTHER;
    node_cfg_ok = (w[NODE_LSB +: 8] <= node_max) && (w[RATE_LSB +: 4] <= RATE_MAX)
      && (w[STYLE_LSB +: 4] <= STYLE_MAX);
  endfunction

  // Saved settings (what software wrote)
  logic [15:0] sv_timeout_reg, sv_timeout_next;
  logic [2:0] sv_mask_reg, sv_mask_next;
  logic [15:0] sv_node_cfg_reg, sv_node_cfg_next;
  logic [15:0] sv_ip_reg, sv_ip_next;
  logic [15:0] rdata_reg, rdata_next;
  // Active settings (what the logic uses)
  logic [15:0] act_timeout_reg, act_timeout_next;
  logic [2:0] act_mask_reg, act_mask_next;
  logic [15:0] act_node_cfg_reg, act_node_cfg_next;
  // Supervision state
  fcw_state_type state_reg, state_next;
  logic [15:0] ms_cnt_reg, ms_cnt_next; // Milliseconds of silence
  logic last_b15_reg, last_b15_next; // Last keepalive bit, for toggle style
  logic [KEY_CNT_W-1:0] key_ms_reg, key_ms_next; // Reset key hold time
  logic key_done_reg, key_done_next; // One reload per key press

  logic ms_tick;
  logic key_tick; // Free-running millisecond, for the reset key
  logic din_legal;
  logic ctrl_legal;
  logic legal_msg;
  logic fb_used;
  logic key_fire;
  logic reload;
  logic trip;

  // Supervision timebase, realigned by each legal message
  fcw_ms_tick #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .restart(legal_msg),
    .ms_tick(ms_tick)
  );

  // Separate timebase for the key hold, since steady traffic keeps restarting the other one
  fcw_ms_tick #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_key_tick (
    .clk(clk),
    .rst_n(rst_n),
    .restart(1'b0),
    .ms_tick(key_tick)
  );

  // Legal message detection
  always_comb
  begin
    din_legal = 1'b0;
    if (din_word_wr && !profile_mode)
    begin
      unique case (act_node_cfg_reg[STYLE_LSB +: 4])
        STYLE_LEVEL: din_legal = din_word[DIN_KEEP_BIT];
        STYLE_TOGGLE: din_legal = din_word[DIN_KEEP_BIT] ^ last_b15_reg;
        STYLE_BOARD: din_legal = iface_board_ok;
        default: din_legal = 1'b0; // Unreachable: range checked on write
      endcase
    end
    ctrl_legal = ctrl_word_wr && profile_mode && ctrl_word[CTRL_KEEP_BIT];
    legal_msg = din_legal || ctrl_legal;
  end

  // Fieldbus counts only when it really carries both commands and references
  assign fb_used = ctrl_method_fb && source_sel_fb && !local_remote_input;

  // Reset key held past the limit, or serial reset, reloads everything
  assign key_fire = reset_key && !key_done_reg && key_tick
    && key_ms_reg == KEY_CNT_W'(KEY_HOLD_MS);
  assign reload = board_reset_command || key_fire;

  // Trip: armed, nonzero timeout, fieldbus in use, silence reached timeout
  assign trip = (state_reg == ST_ARMED) && (act_timeout_reg != 16'h0000)
    && fb_used && (ms_cnt_reg >= act_timeout_reg);

  // Settings store: timeout, mask and node config writes are range checked, saved copy only
  always_comb
  begin
    sv_timeout_next = sv_timeout_reg;
    sv_mask_next = sv_mask_reg;
    sv_node_cfg_next = sv_node_cfg_reg;
    sv_ip_next = sv_ip_reg;
    if (par_wr)
    begin
      // Out-of-range writes are dropped so the store never holds junk
      unique case (par_addr)
        TIMEOUT_ADDR:
          if (par_wdata <= TIMEOUT_MAX)
            sv_timeout_next = par_wdata;
        AOUT_MASK_ADDR:
          if (par_wdata[15:3] == 13'h0000)
            sv_mask_next = par_wdata[2:0];
        NODE_CFG_ADDR:
          if (node_cfg_ok(par_wdata, profile_mode))
            sv_node_cfg_next = par_wdata;
        IP_RST_ADDR:
          sv_ip_next = par_wdata;
        default:
          sv_ip_next = sv_ip_reg; // Unmapped writes ignored
      endcase
    end
  end

  // Read mux: saved values, unmapped addresses read zero
  always_comb
  begin
    unique case (par_addr)
      TIMEOUT_ADDR: rdata_next = sv_timeout_reg;
      AOUT_MASK_ADDR: rdata_next = {13'h0000, sv_mask_reg};
      NODE_CFG_ADDR: rdata_next = sv_node_cfg_reg;
      IP_RST_ADDR: rdata_next = sv_ip_reg;
      default: rdata_next = 16'h0000;
    endcase
  end

  // Active settings change only on a reload
  always_comb
  begin
    act_timeout_next = act_timeout_reg;
    act_mask_next = act_mask_reg;
    act_node_cfg_next = act_node_cfg_reg;
    if (reload)
    begin
      act_timeout_next = sv_timeout_reg;
      act_mask_next = sv_mask_reg;
      act_node_cfg_next = sv_node_cfg_reg;
    end
  end

  // Supervision next state and silence counter
  always_comb
  begin
    state_next = state_reg;
    ms_cnt_next = ms_cnt_reg;
    unique case (state_reg)
      ST_IDLE:
        if (legal_msg)
          state_next = ST_ARMED;
      ST_ARMED:
        if (trip)
          state_next = ST_TRIP;
      ST_TRIP:
        state_next = ST_TRIP; // Sticky until a board reset command or a long reset key hold
    endcase
    if (state_reg != ST_ARMED || legal_msg)
      ms_cnt_next = 16'h0000;
    else if (ms_tick && ms_cnt_reg != 16'hffff)
      ms_cnt_next = ms_cnt_reg + 16'h0001;
    if (reload)
    begin
      // Reset drops the alarm and waits for the first message again
      state_next = ST_IDLE;
      ms_cnt_next = 16'h0000;
    end
  end

  // Keepalive bit history and reset key timer
  always_comb
  begin
    last_b15_next = last_b15_reg;
    if (din_word_wr)
      last_b15_next = din_word[DIN_KEEP_BIT];
    key_ms_next = key_ms_reg;
    key_done_next = key_done_reg;
    if (!reset_key)
    begin
      key_ms_next = '0;
      key_done_next = 1'b0;
    end
    else if (key_fire)
      key_done_next = 1'b1;
    else if (key_tick && !key_done_reg)
      key_ms_next = key_ms_reg + KEY_CNT_W'(1);
  end

  // All state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sv_timeout_reg <= TIMEOUT_RST;
      sv_mask_reg <= MASK_RST;
      sv_node_cfg_reg <= {STYLE_RST, RATE_RST, NODE_RST};
      sv_ip_reg <= IP_RST_RST;
      rdata_reg <= 16'h0000;
      act_timeout_reg <= TIMEOUT_RST;
      act_mask_reg <= MASK_RST;
      act_node_cfg_reg <= {STYLE_RST, RATE_RST, NODE_RST};
      state_reg <= ST_IDLE;
      ms_cnt_reg <= 16'h0000;
      last_b15_reg <= 1'b0;
      key_ms_reg <= '0;
      key_done_reg <= 1'b0;
    end
    else
    begin
      sv_timeout_reg <= sv_timeout_next;
      sv_mask_reg <= sv_mask_next;
      sv_node_cfg_reg <= sv_node_cfg_next;
      sv_ip_reg <= sv_ip_next;
      rdata_reg <= rdata_next;
      act_timeout_reg <= act_timeout_next;
      act_mask_reg <= act_mask_next;
      act_node_cfg_reg <= act_node_cfg_next;
      state_reg <= state_next;
      ms_cnt_reg <= ms_cnt_next;
      last_b15_reg <= last_b15_next;
      key_ms_reg <= key_ms_next;
      key_done_reg <= key_done_next;
    end
  end

  // Outputs, all straight from registers
  assign par_rdata = rdata_reg;
  assign comm_suspended_alarm = (state_reg == ST_TRIP);
  assign supervision_armed = (state_reg == ST_ARMED);
  assign link_timeout_setting = act_timeout_reg;
  assign aout_override_mask = act_mask_reg;
  assign node_id_setting = act_node_cfg_reg[NODE_LSB +: 8];
  assign link_rate_setting = act_node_cfg_reg[RATE_LSB +: 4];
  assign keepalive_style_setting = act_node_cfg_reg[STYLE_LSB +: 4];

  a_trip_on_silence: assert property (@(posedge clk) disable iff (!rst_n)
    trip && !reload |=> comm_suspended_alarm)
    else $error("silence past timeout did not raise alarm");

  a_zero_no_alarm: assert property (@(posedge clk) disable iff (!rst_n)
    act_timeout_reg == 16'h0000 |-> !comm_suspended_alarm)
    else $error("alarm with zero timeout");

  a_din_level: assert property (@(posedge clk) disable iff (!rst_n)
    !profile_mode && keepalive_style_setting == STYLE_LEVEL && !din_word[DIN_KEEP_BIT]
    && !ctrl_word_wr |-> !legal_msg)
    else $error("input word without keepalive bit counted");

  a_profile_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
    profile_mode && !(ctrl_word_wr && ctrl_word[CTRL_KEEP_BIT]) |-> !legal_msg)
    else $error("profile keepalive without control bit 11");

  a_idle_until_first: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_IDLE && !legal_msg |=> state_reg == ST_IDLE)
    else $error("supervision armed without a legal message");

  a_unused_no_trip: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(comm_suspended_alarm) |-> $past(fb_used))
    else $error("alarm while fieldbus not in use");

  a_reset_clears: assert property (@(posedge clk) disable iff (!rst_n)
    reload |=> !comm_suspended_alarm && !supervision_armed
    && link_timeout_setting == $past(sv_timeout_reg))
    else $error("board reset did not clear alarm and reload");

  a_settings_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !reload |=> $stable(link_timeout_setting) && $stable(aout_override_mask)
    && $stable(node_id_setting))
    else $error("active settings changed without reset");

  a_timeout_range: assert property (@(posedge clk) disable iff (!rst_n)
    par_wr && par_addr == TIMEOUT_ADDR && par_wdata > TIMEOUT_MAX
    |=> $stable(sv_timeout_reg))
    else $error("out of range timeout accepted");

  a_legal_restart: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_ARMED && legal_msg && !trip ##1 state_reg == ST_ARMED
    |-> ms_cnt_reg == 16'h0000)
    else $error("legal message did not restart timeout");
endmodule

// ### fcw_master_model.sv
// Fieldbus master model sending periodic keepalive writes
`timescale 1ns/1ps
module fcw_master_model #(
  parameter int GAP = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic bad,
  input wire logic profile_mode,
  input wire logic [3:0] style,
  output logic din_word_wr,
  output logic [15:0] din_word,
  output logic ctrl_word_wr,
  output logic [15:0] ctrl_word
);
  import fcw_pkg::*;
  int cnt; // Cycles since last write
  logic tog; // Keepalive bit sent last
  // One write every GAP+1 cycles while running; bad drops the keepalive bit except in toggle style
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      tog <= 1'b0;
      din_word_wr <= 1'b0;
      ctrl_word_wr <= 1'b0;
      din_word <= 16'h0000;
      ctrl_word <= 16'h0000;
    end
    else
    begin
      din_word_wr <= 1'b0;
      ctrl_word_wr <= 1'b0;
      // Idle words flip so a stale value is never seen as fresh
      din_word <= ~din_word;
      ctrl_word <= ~ctrl_word;
      cnt <= (run && cnt < GAP) ? cnt + 1 : 0;
      if (run && cnt == GAP)
      begin
        if (profile_mode)
        begin
          ctrl_word_wr <= 1'b1;
          ctrl_word <= bad ? 16'h0000 : 16'h0800;
        end
        else
        begin
          din_word_wr <= 1'b1;
          din_word <= {(style == STYLE_TOGGLE) ? ~tog : ~bad, 15'h0000};
          tog <= ~tog;
        end
      end
    end
  end
endmodule

// ### fcw_comm_watchdog_tb_top.sv
// Self-checking bench for the fieldbus communication watchdog
`timescale 1ns/1ps
module fcw_comm_watchdog_tb_top;
  import fcw_pkg::*;
  localparam int CPM = 10; // Short ms so the 5 s key hold fits
  typedef struct {logic p; logic [15:0] a, d, e;} fcw_row_type;
  logic clk, rst_n, par_wr, profile_mode, iface_board_ok, ctrl_method_fb, source_sel_fb;
  logic local_remote_input, board_reset_command, reset_key, run, bad;
  logic din_word_wr, ctrl_word_wr, alarm, armed;
  logic [15:0] par_addr, par_wdata, par_rdata, din_word, ctrl_word, tmo, rv;
  logic [2:0] mask;
  logic [7:0] node;
  logic [3:0] rate, style;
  int n_errors = 0;
  int n_checks = 0;
  int since = 0; // Cycles since the last master write
  int k;
  // Write, refused write and readback cases
  fcw_row_type rows [12] = '{
    '{0, TIMEOUT_ADDR, 16'hea60, 16'hea60}, '{0, TIMEOUT_ADDR, 16'hea61, 16'hea60},
    '{0, AOUT_MASK_ADDR, 16'h0007, 16'h0007}, '{0, AOUT_MASK_ADDR, 16'h0008, 16'h0007},
    '{0, NODE_CFG_ADDR, 16'h233f, 16'h233f}, '{0, NODE_CFG_ADDR, 16'h2040, 16'h233f},
    '{0, NODE_CFG_ADDR, 16'h2403, 16'h233f}, '{0, NODE_CFG_ADDR, 16'h3003, 16'h233f},
    '{0, 16'h0100, 16'h1234, 16'h0000}, '{0, IP_RST_ADDR, 16'h0001, 16'h0001},
    '{1, NODE_CFG_ADDR, 16'h007e, 16'h007e}, '{1, NODE_CFG_ADDR, 16'h007f, 16'h007e}};

  fcw_comm_watchdog #(.CYCLES_PER_MS(CPM)) i_dut (.clk, .rst_n, .par_addr, .par_wr,
    .par_wdata, .par_rdata, .profile_mode, .din_word_wr, .din_word, .ctrl_word_wr,
    .ctrl_word, .iface_board_ok, .ctrl_method_fb, .source_sel_fb, .local_remote_input,
    .board_reset_command, .reset_key, .comm_suspended_alarm(alarm),
    .supervision_armed(armed), .link_timeout_setting(tmo), .aout_override_mask(mask),
    .node_id_setting(node), .link_rate_setting(rate), .keepalive_style_setting(style));

  fcw_master_model #(.GAP(10)) i_master (.clk, .rst_n, .run, .bad, .profile_mode,
    .style(style), .din_word_wr, .din_word, .ctrl_word_wr, .ctrl_word);

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Silence counter, for the trip time
  always @(posedge clk)
    since <= (din_word_wr || ctrl_word_wr) ? 0 : since + 1;

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Wait n edges, then step just past the edge
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task wr(input logic [15:0] a, input logic [15:0] d);
    par_addr = a;
    par_wdata = d;
    par_wr = 1'b1;
    cyc(1);
    par_wr = 1'b0;
  endtask

  // Registered read: two edges so a write just before has landed
  task rd(input logic [15:0] a);
    par_addr = a;
    cyc(2);
    rv = par_rdata;
  endtask

  // Board reset pulse loads the saved settings
  task rld;
    board_reset_command = 1'b1;
    cyc(1);
    board_reset_command = 1'b0;
  endtask

  // Bounded wait for the alarm; running out ends the run
  task wait_al(input int lim);
    k = 0;
    while (alarm !== 1'b1 && k < lim)
    begin
      cyc(1);
      k++;
    end
    if (alarm !== 1'b1)
    begin
      chk("alarm", 16'(alarm), 16'h0001);
      conclude();
    end
  endtask

  initial
  begin
    {par_wr, profile_mode, local_remote_input, board_reset_command, reset_key} = '0;
    {run, bad, par_addr, par_wdata} = '0;
    {iface_board_ok, ctrl_method_fb, source_sel_fb} = 3'b111;
    rst_n = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    chk("timeout", tmo, TIMEOUT_RST);
    chk("mask", 16'(mask), 16'h0000);
    chk("node", 16'(node), 16'h0000);
    $display("test reset done");
    // Ordinary register cases
    foreach (rows[i])
    begin
      profile_mode = rows[i].p;
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("readback", rv, rows[i].e);
    end
    profile_mode = 1'b0;
    chk("unapplied", tmo, 16'h0000);
    rld();
    chk("timeout", tmo, 16'hea60);
    chk("mask", 16'(mask), 16'h0007);
    chk("node", 16'(node), 16'h007e);
    $display("test registers done");
    // Every rate and style code; ends on toggle style
    for (int i = 0; i < 4; i++)
    begin
      wr(NODE_CFG_ADDR, {4'((i + 1) % 3), 4'(i), 8'h05});
      rld();
      chk("rate", 16'(rate), 16'(i));
      chk("style", 16'(style), 16'((i + 1) % 3));
    end
    $display("test codes done");
    wr(TIMEOUT_ADDR, 16'h0003);
    rld();
    cyc(100);
    chk("armed", 16'(armed), 16'h0000);
    chk("alarm", 16'(alarm), 16'h0000);
    run = 1'b1;
    cyc(200);
    chk("armed", 16'(armed), 16'h0001);
    chk("alarm", 16'(alarm), 16'h0000);
    run = 1'b0;
    wait_al(60);
    chk("trip gap", 16'(since >= 3 * CPM && since <= 3 * CPM + 3), 16'h0001);
    run = 1'b1;
    cyc(50);
    chk("alarm held", 16'(alarm), 16'h0001);
    rld();
    chk("alarm", 16'(alarm), 16'h0000);
    $display("test trip done");
    // Level style with the keepalive bit missing never arms
    bad = 1'b1;
    wr(NODE_CFG_ADDR, 16'h0005);
    rld();
    cyc(100);
    chk("armed", 16'(armed), 16'h0000);
    bad = 1'b0;
    cyc(30);
    chk("armed", 16'(armed), 16'h0001);
    local_remote_input = 1'b1;
    run = 1'b0;
    cyc(100);
    chk("alarm", 16'(alarm), 16'h0000);
    local_remote_input = 1'b0;
    wait_al(10);
    wr(TIMEOUT_ADDR, 16'h0000);
    rld();
    chk("alarm", 16'(alarm), 16'h0000);
    run = 1'b1;
    cyc(30);
    run = 1'b0;
    cyc(100);
    chk("alarm", 16'(alarm), 16'h0000);
    // Board-state style: only a good interface board makes a write legal
    iface_board_ok = 1'b0;
    wr(NODE_CFG_ADDR, 16'h2005);
    rld();
    run = 1'b1;
    cyc(30);
    chk("armed", 16'(armed), 16'h0000);
    iface_board_ok = 1'b1;
    cyc(30);
    chk("armed", 16'(armed), 16'h0001);
    run = 1'b0;
    $display("test suppress done");
    // Profile variant: control word keepalive
    profile_mode = 1'b1;
    wr(TIMEOUT_ADDR, 16'h0003);
    rld();
    cyc(50);
    chk("armed", 16'(armed), 16'h0000);
    run = 1'b1;
    cyc(30);
    chk("armed", 16'(armed), 16'h0001);
    bad = 1'b1;
    wait_al(60);
    {run, bad, profile_mode} = '0;
    $display("test profile done");
    // Long key hold reloads the settings
    wr(TIMEOUT_ADDR, 16'h0005);
    reset_key = 1'b1;
    cyc(4990 * CPM);
    chk("early", tmo, 16'h0003);
    cyc(30 * CPM);
    chk("key", tmo, 16'h0005);
    reset_key = 1'b0;
    $display("test key done");
    conclude();
  end
endmodule
